// ===== core/btec_regs.vh
`ifndef BTEC_REGS_VH
`define BTEC_REGS_VH
`define BTEC_RESP_BUS_ERROR 2'h0
`define BTEC_RESP_RETRY 2'h1
`define BTEC_RESP_NORMAL 2'h2
`define BTEC_RESP_WAIT 2'h3
`define BTEC_PST_HALTED 4'h5
`define BTEC_PST_RUN 4'h0
`define BTEC_LINE_BEATS 3'h4
`define BTEC_BEAT_W 2
`endif

// ===== core/btec_resp_decode.v
`timescale 1ns/1ps
`include "btec_regs.vh"
module btec_resp_decode
(
  input wire i_xfer_ack_n,
  input wire i_xfer_error_ack_n,
  output reg [1:0] o_resp
);
  always @*
  begin
    case ({i_xfer_ack_n, i_xfer_error_ack_n})
      2'h2: o_resp = `BTEC_RESP_BUS_ERROR;
      2'h0: o_resp = `BTEC_RESP_RETRY;
      2'h1: o_resp = `BTEC_RESP_NORMAL;
      default: o_resp = `BTEC_RESP_WAIT;
    endcase
  end
endmodule

// ===== core/btec_sync2.v
`timescale 1ns/1ps
module btec_sync2 #(
  parameter WIDTH = 3,
  parameter [WIDTH-1:0] INIT = {WIDTH{1'b1}}
)
(
  input wire i_clock,
  input wire i_rstn,
  input wire i_ce,
  input wire [WIDTH-1:0] i_async,
  output reg [WIDTH-1:0] o_sync
);
  reg [WIDTH-1:0] meta_q;
  always @(posedge i_clock or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      meta_q <= INIT;
      o_sync <= INIT;
    end
    else if (i_ce)
    begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end
endmodule

// ===== core/btec_ctrl.v
// Behaviour
// - Decode acknowledge pair into four results.
// - Bus error ends access, abandons line.
// - Prefetch error deferred until instruction used.
// - Later line beat error only if requested.
// - Misaligned span error on beats one/two immediate.
// - Write or requested read error immediate.
// - Victim line invalidated before fill, stays.
// - Dirty victim restored from push buffer.
// - Push error: keep after fill, invalidate explicit.
// - Write-through error keeps updated line valid.
// - Retry reissues cycle, except snooped push.
// - Locked cycles retried separately, lock held.
// - Burst retry only first beat, else error.
// - Inhibited line retry only initial transfer.
// - Grant negated with retry: release, retry later.
// - Error while stacking state: double fault.
// - Halted drives status code five until reset.
// - Halted negates request, tristates outputs.
// - Handler errors not double; retry unbounded.
`timescale 1ns/1ps
`include "btec_regs.vh"
module btec_ctrl
(
  input wire i_clock,
  input wire i_rstn,
  input wire i_ce,
  input wire i_xfer_ack_n,
  input wire i_xfer_error_ack_n,
  input wire i_bus_grant_in_n,
  input wire i_start,
  input wire i_is_line,
  input wire i_is_burst,
  input wire i_is_write,
  input wire i_is_prefetch,
  input wire i_is_push,
  input wire i_push_after_fill,
  input wire i_cache_push_instr,
  input wire i_write_through,
  input wire i_misaligned,
  input wire [1:0] i_req_beat,
  input wire i_req_valid,
  input wire i_victim_valid,
  input wire i_victim_dirty,
  input wire i_locked,
  input wire i_locked_last,
  input wire i_snoop_inval,
  input wire i_stacking,
  input wire i_use_prefetch,
  input wire i_flush_prefetch,
  output reg o_busy,
  output reg o_done,
  output reg o_retry_issue,
  output reg o_exc_now,
  output reg o_exc_deferred,
  output reg o_line_cached,
  output reg o_victim_inval,
  output reg o_victim_restore,
  output reg o_push_line_inval,
  output reg o_wt_line_keep,
  output reg o_lock_n,
  output reg o_atomic_final_cycle_n,
  output reg o_bus_request_out_n,
  output reg o_outputs_oe,
  output reg o_halted,
  output reg [3:0] o_proc_status_code,
  output reg [1:0] o_beat
);
  // ----------------------------------------
  // Input synchronisation and decode.
  // ----------------------------------------
  wire [2:0] pins_s;
  wire [1:0] resp;
  wire ack_s;
  wire err_s;
  wire grant_s;
  btec_sync2 #(.WIDTH(3), .INIT(3'h7)) u_sync
  (
    .i_clock(i_clock),
    .i_rstn(i_rstn),
    .i_ce(i_ce),
    .i_async({i_xfer_ack_n, i_xfer_error_ack_n, i_bus_grant_in_n}),
    .o_sync(pins_s)
  );
  assign ack_s = pins_s[2];
  assign err_s = pins_s[1];
  assign grant_s = pins_s[0];
  btec_resp_decode u_dec
  (
    .i_xfer_ack_n(ack_s),
    .i_xfer_error_ack_n(err_s),
    .o_resp(resp)
  );

  // ----------------------------------------
  // State machine.
  // ----------------------------------------
  localparam ST_IDLE = 3'h0;
  localparam ST_CYCLE = 3'h1;
  localparam ST_RELEASE = 3'h2;
  localparam ST_REARB = 3'h3;
  localparam ST_HALT = 3'h4;

  reg [2:0] state_q;
  reg [2:0] state_d;
  reg line_q;
  reg burst_q;
  reg write_q;
  reg prefetch_q;
  reg push_q;
  reg push_fill_q;
  reg wt_q;
  reg misal_q;
  reg [1:0] req_beat_q;
  reg req_valid_q;
  reg victim_dirty_q;
  reg locked_last_q;
  reg pf_err_q;

  wire last_beat;
  wire retry_ok;
  wire is_error;
  wire want_now;
  wire relinquish;
  assign last_beat = !line_q || (o_beat == 2'h3);
  assign retry_ok = !line_q || (o_beat == 2'h0);
  assign is_error = (resp == `BTEC_RESP_BUS_ERROR) ||
                    ((resp == `BTEC_RESP_RETRY) && !retry_ok);
  assign relinquish = (resp == `BTEC_RESP_RETRY) && retry_ok && grant_s;
  assign want_now = write_q || misal_q && (o_beat <= 2'h1) ||
                    req_valid_q && (!line_q || req_beat_q == o_beat) && !prefetch_q;

  always @*
  begin
    state_d = state_q;
    case (state_q)
      ST_IDLE:
      begin
        if (i_start)
        begin
          state_d = ST_CYCLE;
        end
      end
      ST_CYCLE:
      begin
        if (resp != `BTEC_RESP_WAIT)
        begin
          if (is_error && i_stacking)
          begin
            state_d = ST_HALT;
          end
          else if (is_error)
          begin
            state_d = ST_IDLE;
          end
          else if (relinquish)
          begin
            state_d = ST_RELEASE;
          end
          else if (resp == `BTEC_RESP_RETRY && push_q && i_snoop_inval)
          begin
            state_d = ST_IDLE;
          end
          else if (resp == `BTEC_RESP_NORMAL && last_beat)
          begin
            state_d = ST_IDLE;
          end
        end
      end
      ST_RELEASE:
      begin
        state_d = ST_REARB;
      end
      ST_REARB:
      begin
        if (!grant_s)
        begin
          state_d = (push_q && i_snoop_inval) ? ST_IDLE : ST_CYCLE;
        end
      end
      ST_HALT:
      begin
        state_d = ST_HALT;
      end
      default:
      begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always @(posedge i_clock or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      state_q <= ST_IDLE;
      {line_q, burst_q, write_q, prefetch_q, push_q, push_fill_q} <= 6'h00;
      {wt_q, misal_q, req_valid_q, victim_dirty_q, locked_last_q} <= 5'h00;
      req_beat_q <= 2'h0;
      pf_err_q <= 1'b0;
      o_busy <= 1'b0;
      o_done <= 1'b0;
      o_retry_issue <= 1'b0;
      o_exc_now <= 1'b0;
      o_exc_deferred <= 1'b0;
      o_line_cached <= 1'b0;
      o_victim_inval <= 1'b0;
      o_victim_restore <= 1'b0;
      o_push_line_inval <= 1'b0;
      o_wt_line_keep <= 1'b0;
      o_lock_n <= 1'b1;
      o_atomic_final_cycle_n <= 1'b1;
      o_bus_request_out_n <= 1'b1;
      o_outputs_oe <= 1'b1;
      o_halted <= 1'b0;
      o_proc_status_code <= `BTEC_PST_RUN;
      o_beat <= 2'h0;
    end
    else if (i_ce)
    begin
      state_q <= state_d;
      o_done <= 1'b0;
      o_retry_issue <= 1'b0;
      o_exc_now <= 1'b0;
      o_line_cached <= 1'b0;
      o_victim_inval <= 1'b0;
      o_victim_restore <= 1'b0;
      o_push_line_inval <= 1'b0;
      o_wt_line_keep <= 1'b0;
      o_busy <= (state_d == ST_CYCLE) || (state_d == ST_REARB);
      o_bus_request_out_n <= !((state_d == ST_CYCLE) || (state_d == ST_REARB));
      if (i_flush_prefetch)
      begin
        o_exc_deferred <= 1'b0;
        pf_err_q <= 1'b0;
      end
      else if (i_use_prefetch && pf_err_q)
      begin
        o_exc_now <= 1'b1;
        pf_err_q <= 1'b0;
        o_exc_deferred <= 1'b0;
      end
      case (state_q)
        ST_IDLE:
        begin
          if (i_start)
          begin
            line_q <= i_is_line;
            burst_q <= i_is_burst;
            write_q <= i_is_write;
            prefetch_q <= i_is_prefetch;
            push_q <= i_is_push;
            push_fill_q <= i_push_after_fill;
            wt_q <= i_write_through;
            misal_q <= i_misaligned;
            req_beat_q <= i_req_beat;
            req_valid_q <= i_req_valid;
            victim_dirty_q <= i_victim_dirty;
            locked_last_q <= i_locked_last;
            o_beat <= 2'h0;
            o_victim_inval <= i_is_line && !i_is_write && i_victim_valid;
            o_lock_n <= !i_locked;
            o_atomic_final_cycle_n <= !i_locked_last;
          end
        end
        ST_CYCLE:
        begin
          if (resp != `BTEC_RESP_WAIT)
          begin
            if (is_error)
            begin
              o_done <= 1'b1;
              o_beat <= 2'h0;
              o_lock_n <= 1'b1;
              o_atomic_final_cycle_n <= 1'b1;
              if (!i_stacking)
              begin
                if (prefetch_q)
                begin
                  pf_err_q <= 1'b1;
                  o_exc_deferred <= 1'b1;
                end
                else if (want_now)
                begin
                  o_exc_now <= 1'b1;
                end
              end
              o_victim_restore <= line_q && !write_q && victim_dirty_q;
              o_push_line_inval <= push_q && (i_cache_push_instr || !push_fill_q);
              o_wt_line_keep <= write_q && wt_q;
            end
            else if (resp == `BTEC_RESP_RETRY)
            begin
              o_retry_issue <= !(push_q && i_snoop_inval);
              o_lock_n <= o_lock_n;
              o_atomic_final_cycle_n <= !locked_last_q;
            end
            else if (last_beat)
            begin
              o_done <= 1'b1;
              o_line_cached <= line_q && !write_q;
              o_beat <= 2'h0;
              o_atomic_final_cycle_n <= 1'b1;
              o_lock_n <= !(o_lock_n == 1'b0 && !locked_last_q);
            end
            else
            begin
              o_beat <= o_beat + 2'h1;
            end
          end
        end
        ST_REARB:
        begin
          if (!grant_s)
          begin
            o_retry_issue <= !(push_q && i_snoop_inval);
          end
        end
        ST_HALT:
        begin
          o_halted <= 1'b1;
          o_proc_status_code <= `BTEC_PST_HALTED;
          o_bus_request_out_n <= 1'b1;
          o_outputs_oe <= 1'b0;
          o_busy <= 1'b0;
          o_lock_n <= 1'b1;
          o_atomic_final_cycle_n <= 1'b1;
        end
        default:
        begin
          o_beat <= o_beat;
        end
      endcase
    end
  end
endmodule

// ===== sim/btec_ctrl_checker.sv
`timescale 1ns/1ps
module btec_ctrl_checker
(
  input wire i_clock,
  input wire i_rstn,
  input wire i_xfer_ack_n,
  input wire i_xfer_error_ack_n,
  input wire o_busy,
  input wire o_done,
  input wire o_retry_issue,
  input wire o_lock_n,
  input wire o_atomic_final_cycle_n,
  input wire o_bus_request_out_n,
  input wire o_outputs_oe,
  input wire o_halted,
  input wire [3:0] o_proc_status_code
);
  default clocking dc @(posedge i_clock);
  endclocking
  default disable iff (!i_rstn);
  wire ok_w = !i_xfer_ack_n || !i_xfer_error_ack_n;
  halt_code_a: assert property (o_halted |-> o_proc_status_code == 4'h5)
    else $error("status code wrong while halted");
  halt_hold_a: assert property (o_halted |=> o_halted)
    else $error("halt left without reset");
  halt_release_a: assert property (o_halted |-> o_bus_request_out_n && !o_outputs_oe)
    else $error("bus not released while halted");
  run_code_a: assert property (!o_halted |-> o_proc_status_code == 4'h0)
    else $error("status code wrong while running");
  done_cause_a: assert property (o_done |-> $past(ok_w, 3) || $past(ok_w, 4))
    else $error("done without any acknowledge");
  done_idle_a: assert property (o_done |-> !o_busy && !o_retry_issue)
    else $error("done while busy or retrying");
  lock_hold_a: assert property (!o_lock_n && o_retry_issue |=> !o_lock_n)
    else $error("lock dropped on retry");
  final_hold_a: assert property (!o_atomic_final_cycle_n && o_retry_issue
    |=> !o_atomic_final_cycle_n)
    else $error("final lock dropped on retry");
  cover property (o_done);
  cover property (o_retry_issue);
  cover property (o_halted);
endmodule
bind btec_ctrl btec_ctrl_checker i_chk (.i_clock(i_clock), .i_rstn(i_rstn),
  .i_xfer_ack_n(i_xfer_ack_n), .i_xfer_error_ack_n(i_xfer_error_ack_n),
  .o_busy(o_busy), .o_done(o_done), .o_retry_issue(o_retry_issue), .o_lock_n(o_lock_n),
  .o_atomic_final_cycle_n(o_atomic_final_cycle_n), .o_outputs_oe(o_outputs_oe),
  .o_bus_request_out_n(o_bus_request_out_n), .o_halted(o_halted),
  .o_proc_status_code(o_proc_status_code));

// ===== sim/btec_resp_model.sv
`timescale 1ns/1ps
module btec_resp_model
(
  input wire i_clock,
  input wire i_busy,
  input wire [1:0] i_resp,
  input wire i_relinq,
  output reg o_xfer_ack_n,
  output reg o_xfer_error_ack_n,
  output reg o_bus_grant_in_n
);
  reg [3:0] gap_q;
  initial
  begin
    gap_q = 4'h3;
    o_xfer_ack_n = 1'b1;
    o_xfer_error_ack_n = 1'b1;
    o_bus_grant_in_n = 1'b0;
  end
  // Each pair is asserted for one edge, then released to the pull-up level.
  always @(negedge i_clock)
  begin
    o_xfer_ack_n <= 1'b1;
    o_xfer_error_ack_n <= 1'b1;
    o_bus_grant_in_n <= i_relinq && gap_q > 4'h3;
    if (!i_busy)
      gap_q <= 4'h3;
    else if (gap_q != 4'h0)
      gap_q <= gap_q - 4'h1;
    else
    begin
      gap_q <= 4'h6;
      o_xfer_ack_n <= !(i_resp == 2'h1 || i_resp == 2'h2);
      o_xfer_error_ack_n <= !(i_resp == 2'h0 || i_resp == 2'h1);
      o_bus_grant_in_n <= i_relinq && i_resp == 2'h1;
    end
  end
endmodule

// ===== sim/testbench.sv
`timescale 1ns/1ps
module testbench;
  reg i_clock, i_rstn, i_start, relinq;
  reg [15:0] attr;
  reg [3:0] live;
  reg [1:0] resp, resp1;
  reg s_done, s_retry, s_exc, s_rel, s_cached, s_vres;
  integer n_mismatch, n_checks;
  wire ack_n, err_n, grant_n, o_busy, o_done, o_retry_issue, o_exc_now, o_exc_deferred;
  wire o_line_cached, o_victim_restore, o_bus_request_out_n, o_outputs_oe, o_halted;
  wire [3:0] o_proc_status_code;
  btec_resp_model i_btec_resp_model (.i_clock(i_clock), .i_busy(o_busy), .i_resp(resp),
    .i_relinq(relinq), .o_xfer_ack_n(ack_n), .o_xfer_error_ack_n(err_n),
    .o_bus_grant_in_n(grant_n));
  btec_ctrl i_btec_ctrl (.i_clock(i_clock), .i_rstn(i_rstn), .i_ce(1'b1),
    .i_xfer_ack_n(ack_n), .i_xfer_error_ack_n(err_n), .i_bus_grant_in_n(grant_n),
    .i_start(i_start), .i_is_line(attr[0]), .i_is_burst(attr[1]), .i_is_write(attr[2]),
    .i_is_prefetch(attr[3]), .i_is_push(attr[4]), .i_push_after_fill(attr[5]),
    .i_cache_push_instr(attr[6]), .i_write_through(attr[7]), .i_misaligned(attr[8]),
    .i_req_valid(attr[9]), .i_victim_valid(attr[10]), .i_victim_dirty(attr[11]),
    .i_locked(attr[12]), .i_locked_last(attr[13]), .i_req_beat(attr[15:14]),
    .i_snoop_inval(live[0]), .i_stacking(live[1]), .i_use_prefetch(live[2]),
    .i_flush_prefetch(live[3]), .o_busy(o_busy), .o_done(o_done),
    .o_retry_issue(o_retry_issue), .o_exc_now(o_exc_now), .o_exc_deferred(o_exc_deferred),
    .o_line_cached(o_line_cached), .o_victim_inval(), .o_victim_restore(o_victim_restore),
    .o_push_line_inval(), .o_wt_line_keep(), .o_lock_n(), .o_atomic_final_cycle_n(),
    .o_bus_request_out_n(o_bus_request_out_n), .o_outputs_oe(o_outputs_oe),
    .o_halted(o_halted), .o_proc_status_code(o_proc_status_code), .o_beat());
  initial
  begin
    i_clock = 1'b0;
    forever #4 i_clock = ~i_clock;
  end
  task check(input [3:0] seen, input [3:0] exp);
  begin
    n_checks = n_checks + 1;
    if (seen !== exp)
    begin
      n_mismatch = n_mismatch + 1;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  end
  endtask
  task conclude;
  begin
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  end
  endtask
  // Starts one cycle and gathers its pulses until done is seen or 200 clocks pass.
  task go(input [15:0] a, input [1:0] r0, input [1:0] r1);
    integer k;
  begin
    attr = a;
    resp = r0;
    resp1 = r1;
    {s_done, s_retry, s_exc, s_rel, s_cached, s_vres} = 6'h0;
    i_start = 1'b1;
    @(negedge i_clock);
    i_start = 1'b0;
    for (k = 0; k < 200 && !s_done; k = k + 1)
    begin
      @(negedge i_clock);
      if (o_retry_issue || o_bus_request_out_n || i_btec_ctrl.o_beat == 2'h1)
        resp = resp1;
      s_done = s_done | o_done;
      s_retry = s_retry | o_retry_issue;
      s_exc = s_exc | o_exc_now;
      s_rel = s_rel | (o_bus_request_out_n & !o_done);
      s_cached = s_cached | o_line_cached;
      s_vres = s_vres | o_victim_restore;
    end
  end
  endtask
  task t_basic;
  begin
    go(16'h0200, 2'h2, 2'h2);
    check({s_done, s_exc}, 4'h2);
    go(16'h0084, 2'h0, 2'h0);
    check({s_exc, o_halted}, 4'h2);
    relinq = 1'b1;
    go(16'h3200, 2'h1, 2'h2);
    relinq = 1'b0;
    check({s_retry, s_done, s_rel}, 4'h7);
  end
  endtask
  task t_line;
  begin
    go(16'h4203, 2'h2, 2'h1);
    check({s_retry, s_exc}, 4'h1);
    go(16'h0e03, 2'h2, 2'h0);
    check({s_exc, s_cached, s_vres}, 4'h1);
  end
  endtask
  task t_prefetch;
  begin
    go(16'h0008, 2'h0, 2'h0);
    check({s_exc, o_exc_deferred}, 4'h1);
    live = 4'h4;
    repeat (4) @(negedge i_clock);
    live = 4'h0;
    check(o_exc_deferred, 4'h0);
  end
  endtask
  task t_halt;
  begin
    live = 4'h2;
    go(16'h0004, 2'h0, 2'h0);
    @(negedge i_clock);
    check({o_halted, o_bus_request_out_n, o_outputs_oe}, 4'h6);
    check(o_proc_status_code, 4'h5);
    i_rstn = 1'b0;
    live = 4'h0;
    repeat (5) @(negedge i_clock);
    i_rstn = 1'b1;
    check(o_proc_status_code, 4'h0);
  end
  endtask
  initial
  begin
    #20000;
    n_mismatch = n_mismatch + 1;
    conclude;
  end
  initial
  begin
    {n_mismatch, n_checks} = 0;
    {i_rstn, i_start, relinq, attr, live, resp, resp1} = 0;
    repeat (5) @(negedge i_clock);
    i_rstn = 1'b1;
    t_basic;
    t_line;
    t_prefetch;
    t_halt;
    conclude;
  end
endmodule
